// File: ibs_chan_model.sv
// channel controller model answering commands on the io bus
`timescale 1ns/1ps
module ibs_chan_model (
   // clock and bench control
   input wire logic clk_sys,
   input wire logic mute,
   // io bus
   input wire logic own_bus_request,
   output logic bus_grant,
   input wire logic cmd_strobe,
   input wire logic cmd_global,
   input wire logic cmd_read,
   input wire logic [14:0] cmd_addr,
   output logic chan_reply,
   output logic [15:0] chan_rdata,
   output logic data_not_valid
);
   logic [3:0] wait_r = 4'h0;
   initial begin
      bus_grant = 1'b0;
      chan_reply = 1'b0;
      chan_rdata = 16'h0000;
      data_not_valid = 1'b0;
   end
   // prompt grant, slow reply; data toggles when not answering
   always @(posedge clk_sys) begin
      bus_grant <= own_bus_request;
      wait_r <= cmd_strobe ? wait_r + 4'h1 : 4'h0;
      chan_reply <= cmd_strobe && !cmd_global && !mute && wait_r == 4'h3;
      chan_rdata <= (cmd_strobe && wait_r == 4'h3) ? {cmd_read, cmd_addr} : ~chan_rdata;
      data_not_valid <= cmd_strobe && mute;
   end
endmodule

// File: ibs_hs_timer.sv
// master handshake timer: global end and timeout
`timescale 1ns/1ps
`include "ibs_params.svh"
module ibs_hs_timer (
   // clock and reset
   input wire logic clk_sys,
   input wire logic clk_en,
   input wire logic rst,
   // control
   ibs_tmr_if.tmr t
);
   logic [10:0] cnt_r;
   // counts handshake cycles, restarts whenever the handshake drops
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_r <= 11'h000;
      end else if (clk_en) begin
         if (!t.run) begin
            cnt_r <= 11'h000;
         end else if (!t.tout) begin
            cnt_r <= cnt_r + 11'h001;
         end
      end
   end
   // terminal counts as plain compares
   assign t.glob_done = t.run && t.global_cmd && (cnt_r >= 11'(`IBS_GLOBAL_CYC - 1));
   assign t.tout = t.run && (cnt_r >= 11'(`IBS_TOUT_CYC - 1));
endmodule

// File: ibs_params.svh
// offsets, field positions, reset values and timing counts of the bus interface sequencer
`ifndef IBS_PARAMS_SVH
`define IBS_PARAMS_SVH
// apb byte offsets
`define IBS_A_CTRL 12'h000
`define IBS_A_STAT 12'h004
`define IBS_A_RESP 12'h008
// command message layout: data 31:16, address 15:1, read/write 0
`define IBS_MSG_DATA_LSB 16
`define IBS_MSG_ADDR_LSB 1
`define IBS_MSG_RW_BIT 0
`define IBS_CLR_BIT 22
// address field: register 9:8, global 7, channel 6:3, device 2:0
`define IBS_AD_REG_LSB 8
`define IBS_AD_GLOB_BIT 7
`define IBS_AD_CHDEV_MSB 6
// control register 0 bits
`define IBS_C0_IRQ_MSK 0
`define IBS_C0_SRQ_MSK 1
`define IBS_C0_CLR 6
`define IBS_C0_RST 2'h0
// response status bits
`define IBS_ST_PERR 0
`define IBS_ST_TOUT 1
`define IBS_ST_DNV 2
`define IBS_ST_UNSOL 3
`define IBS_ST_IRQ 4
`define IBS_ST_SRQ 5
`define IBS_ST_LOCAL 6
// timing
`define IBS_CLK_MHZ 40
`define IBS_GLOBAL_NS 1000
`define IBS_GLOBAL_CYC ((`IBS_GLOBAL_NS * `IBS_CLK_MHZ + 999) / 1000)
`define IBS_TOUT_CYC 1024
`define IBS_CLR_CYC 3
`define IBS_INIT_CYC 4
`endif

// File: ibs_pkg.sv
// types shared by the bus interface sequencer files
package ibs_pkg;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h0,
      ST_UNSOL = 4'h1,
      ST_FETCH = 4'h2,
      ST_PCHK  = 4'h3,
      ST_EXEC  = 4'h4,
      ST_HSHK  = 4'h5,
      ST_LOCAL = 4'h6,
      ST_RESP  = 4'h7,
      ST_MADDR = 4'h8,
      ST_MWAIT = 4'h9,
      ST_MFIN  = 4'ha
   } ibs_state_e;
   typedef logic [31:0] ibs_word_t;
   // odd parity over a message word and its parity bit
   function automatic logic ibs_par_bad(input ibs_word_t w, input logic p);
      ibs_par_bad = ~(^{w, p});
   endfunction
endpackage

// File: ibs_seq.sv
// io bus interface sequencer: command, memory slave and unsolicited message control
//
// What this block does
// R1: distinct states for idle, unsolicited, fetch, parity, exec, handshake, local, response, memory.
// R2: message-available from the message unit starts a fetch handshake for the word.
// R3: parity checked on each message; error skips execution and goes to response.
// R4: after execution a response is built, sent to the message unit, then idle.
// R5: message is 15-bit address, 16-bit data, one read/write bit.
// R6: channel 0 device 0 commands operate on local registers, not the bus.
// R7: cpu commands win over memory requests and unsolicited messages.
// R8: the bus is requested and granted before the command handshake is driven.
// R9: global commands end by the sequencer itself after one microsecond.
// R10: addressed commands complete on the channel's reply.
// R11: a handshake not complete within 1024 cycles aborts with timeout status.
// R12: response carries error and special status, and read data for addressed and local reads; global reads capture no data.
// R13: as memory slave only channel reads and writes are served.
// R14: memory write passes address, opcode and data to the cache together, then finishes the handshake.
// R15: memory read passes address, acks address, waits data, drives it, acks data.
// R16: bad cache read parity raises bus parity error before the data ack.
// R17: control register 0 holds interrupt and service masks starting unsolicited messages.
// R18: a transmitted unsolicited message clears both masks until software sets them.
// R19: unsolicited messages are lowest priority; masks stay set while held back.
// R20: no reply is awaited after an unsolicited message.
// R21: control 0 write with bit 22 resets sequencer and channels, not cache.
// R22: initialized at least four clocks after the initialize indication is set.
// R23: initialized only when idle and the bus is quiet.
// R24: bus clear is a three-clock pulse issued after returning to idle.
// R25: all logic except the pin synchroniser resets while adapter reset or power-on is low; the synchroniser resets on sys_rst only.
// R26: interrupt and service lines are synchronised before mask testing.
// R27: the one microsecond end comes from a counter sized from the clock rate.
// R28: abort releases handshake lines, sets status and goes to response.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "ibs_params.svh"
module ibs_seq (
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // reset and initialize pins
   input wire logic adapter_reset_n,
   input wire logic power_on_good,
   input wire logic init_req,
   output logic initialized,
   output logic bus_clear,
   // cache and message unit: command fetch and response
   input wire logic message_available_n,
   output logic msg_fetch,
   input wire logic msg_word_valid,
   input wire logic [31:0] msg_word,
   input wire logic msg_parity,
   output logic rsp_valid,
   output logic [31:0] rsp_word,
   input wire logic rsp_ack,
   // cache and message unit: memory path
   output logic cache_req,
   output logic cache_write,
   output logic [23:0] cache_addr,
   output logic [15:0] cache_wdata,
   input wire logic cache_ack,
   input wire logic cache_done,
   input wire logic [15:0] cache_rdata,
   input wire logic cache_rparity_err,
   // io bus master side
   output logic own_bus_request,
   input wire logic bus_grant,
   output logic cmd_strobe,
   output logic [14:0] cmd_addr,
   output logic [15:0] cmd_data,
   output logic cmd_read,
   output logic cmd_global,
   input wire logic chan_reply,
   input wire logic [15:0] chan_rdata,
   input wire logic data_not_valid,
   // io bus memory slave side
   input wire logic mem_req,
   input wire logic mem_write,
   input wire logic [23:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   output logic mem_addr_ack,
   output logic mem_data_ack,
   output logic [15:0] mem_rdata,
   output logic bus_parity_err,
   // io bus request lines
   input wire logic interrupt_request_n,
   input wire logic channel_service_request_n
);
   ibs_pkg::ibs_state_e state_r, state_nxt;
   logic [3:0] pins_s;
   logic irq_s, srq_s, aro_s, pon_s;
   logic rst_hw, rst_i;
   logic [31:0] msg_r;
   logic msg_par_r;
   logic perr_r, tout_r, dnv_r;
   logic [15:0] rdata_r;
   logic interrupt_mask_flag, service_request_mask_flag;
   logic clr_pend_r;
   logic [1:0] clr_cnt_r;
   logic [2:0] init_cnt_r;
   logic mem_write_r, mem_perr_r, fin_r;
   logic [23:0] mem_addr_r;
   logic [15:0] mem_wdata_r;
   logic [31:0] rsp_word_r;
   logic [15:0] rsp_status;
   logic unsolicited_pending_flag;
   logic is_local, hs_end, loc_wr, apb_wr;
   logic [14:0] msg_addr;
   logic [15:0] msg_data;
   logic [15:0] ctrl0_view;
   ibs_tmr_if tmr ();

   // pin inputs through two flops before use
   ibs_sync u_sync (
      .clk_sys(clk_sys),
      .clk_en(clk_en),
      .sys_rst(sys_rst),
      .d({~interrupt_request_n, ~channel_service_request_n, adapter_reset_n, power_on_good}),
      .q(pins_s)
   );
   assign irq_s = pins_s[3]; // [R26]
   assign srq_s = pins_s[2]; // [R26]
   assign aro_s = pins_s[1];
   assign pon_s = pins_s[0];

   // reset sources; bus clear and initialize also restart the sequencer
   assign rst_hw = sys_rst | ~aro_s | ~pon_s; // [R25]
   assign rst_i = rst_hw | (clr_cnt_r != 2'h0) | (init_req && init_cnt_r == 3'h0); // [R21]

   // handshake timer: global end and timeout from one counter
   ibs_hs_timer u_tmr (
      .clk_sys(clk_sys),
      .clk_en(clk_en),
      .rst(rst_i),
      .t(tmr)
   );
   assign tmr.run = (state_r == ibs_pkg::ST_HSHK);
   assign tmr.global_cmd = msg_addr[`IBS_AD_GLOB_BIT]; // [R27]

   // message field decode
   assign msg_addr = msg_r[`IBS_MSG_ADDR_LSB +: 15]; // [R5]
   assign msg_data = msg_r[`IBS_MSG_DATA_LSB +: 16]; // [R5]
   assign is_local = (msg_addr[`IBS_AD_CHDEV_MSB:0] == 7'h00); // [R6]
   assign hs_end = tmr.tout | (tmr.global_cmd ? tmr.glob_done : chan_reply); // [R9] [R10] [R11]
   assign unsolicited_pending_flag = (interrupt_mask_flag & irq_s) |
      (service_request_mask_flag & srq_s); // [R17]

   // next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ibs_pkg::ST_IDLE: begin
            if (!message_available_n) begin
               state_nxt = ibs_pkg::ST_FETCH; // [R2] [R7]
            end else if (mem_req) begin
               state_nxt = ibs_pkg::ST_MADDR; // [R13]
            end else if (unsolicited_pending_flag) begin
               state_nxt = ibs_pkg::ST_UNSOL; // [R19]
            end
         end
         ibs_pkg::ST_UNSOL: begin
            // a command arriving first pulls the message back, masks untouched
            if (!message_available_n && !rsp_ack) begin
               state_nxt = ibs_pkg::ST_IDLE; // [R7] [R19]
            end else if (rsp_ack) begin
               state_nxt = ibs_pkg::ST_IDLE; // [R20]
            end
         end
         ibs_pkg::ST_FETCH: begin
            if (msg_word_valid) begin
               state_nxt = ibs_pkg::ST_PCHK;
            end
         end
         ibs_pkg::ST_PCHK: begin
            if (ibs_pkg::ibs_par_bad(msg_r, msg_par_r)) begin
               state_nxt = ibs_pkg::ST_RESP; // [R3]
            end else if (is_local) begin
               state_nxt = ibs_pkg::ST_LOCAL; // [R6]
            end else begin
               state_nxt = ibs_pkg::ST_EXEC;
            end
         end
         ibs_pkg::ST_EXEC: begin
            if (bus_grant) begin
               state_nxt = ibs_pkg::ST_HSHK; // [R8]
            end
         end
         ibs_pkg::ST_HSHK: begin
            if (hs_end) begin
               state_nxt = ibs_pkg::ST_RESP; // [R28]
            end
         end
         ibs_pkg::ST_LOCAL: state_nxt = ibs_pkg::ST_RESP;
         ibs_pkg::ST_RESP: begin
            if (rsp_ack) begin
               state_nxt = ibs_pkg::ST_IDLE; // [R4]
            end
         end
         ibs_pkg::ST_MADDR: begin
            if (cache_ack) begin
               state_nxt = ibs_pkg::ST_MWAIT; // [R14] [R15]
            end
         end
         ibs_pkg::ST_MWAIT: begin
            if (cache_done) begin
               state_nxt = ibs_pkg::ST_MFIN;
            end
         end
         ibs_pkg::ST_MFIN: begin
            if (!mem_req) begin
               state_nxt = ibs_pkg::ST_IDLE;
            end
         end
         default: state_nxt = ibs_pkg::ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (rst_i) begin
         state_r <= ibs_pkg::ST_IDLE;
      end else if (clk_en) begin
         state_r <= state_nxt; // [R1]
      end
   end

   // command word capture from the message unit
   always_ff @(posedge clk_sys) begin
      if (rst_i) begin
         msg_r <= 32'h0000_0000;
         msg_par_r <= 1'b0;
      end else if (clk_en && state_r == ibs_pkg::ST_FETCH && msg_word_valid) begin
         msg_r <= msg_word; // [R2]
         msg_par_r <= msg_parity;
      end
   end

   // execution status, cleared at each new fetch
   always_ff @(posedge clk_sys) begin
      if (rst_i) begin
         perr_r <= 1'b0;
         tout_r <= 1'b0;
         dnv_r <= 1'b0;
         rdata_r <= 16'h0000;
      end else if (clk_en) begin
         if (state_r == ibs_pkg::ST_FETCH) begin
            perr_r <= 1'b0;
            tout_r <= 1'b0;
            dnv_r <= 1'b0;
         end
         if (state_r == ibs_pkg::ST_PCHK) begin
            perr_r <= ibs_pkg::ibs_par_bad(msg_r, msg_par_r); // [R3]
         end
         if (state_r == ibs_pkg::ST_HSHK) begin
            if (data_not_valid) begin
               dnv_r <= 1'b1;
            end
            if (tmr.tout && !(tmr.global_cmd ? tmr.glob_done : chan_reply)) begin
               tout_r <= 1'b1; // [R11] [R28]
            end
            if (chan_reply && cmd_read && !tmr.global_cmd) begin
               rdata_r <= chan_rdata; // [R12]
            end
         end
         if (state_r == ibs_pkg::ST_LOCAL && cmd_read) begin
            rdata_r <= msg_addr[`IBS_AD_REG_LSB] ? rsp_status : ctrl0_view; // [R6]
         end
      end
   end

   // control register 0 view and write strobes
   assign ctrl0_view = {9'h000, clr_pend_r, 4'h0, service_request_mask_flag, interrupt_mask_flag};
   assign loc_wr = clk_en && state_r == ibs_pkg::ST_LOCAL && !cmd_read &&
      msg_addr[`IBS_AD_REG_LSB +: 2] == 2'h0;
   assign apb_wr = psel && penable && pwrite && paddr == `IBS_A_CTRL;

   // message masks: set by software, cleared by a sent unsolicited message
   always_ff @(posedge clk_sys) begin
      if (rst_i) begin
         {service_request_mask_flag, interrupt_mask_flag} <= `IBS_C0_RST;
      end else if (clk_en) begin
         if (state_r == ibs_pkg::ST_UNSOL && rsp_ack) begin
            interrupt_mask_flag <= 1'b0; // [R18]
            service_request_mask_flag <= 1'b0; // [R18]
         end else if (loc_wr) begin
            interrupt_mask_flag <= msg_data[`IBS_C0_IRQ_MSK]; // [R17]
            service_request_mask_flag <= msg_data[`IBS_C0_SRQ_MSK];
         end else if (apb_wr) begin
            interrupt_mask_flag <= pwdata[`IBS_C0_IRQ_MSK];
            service_request_mask_flag <= pwdata[`IBS_C0_SRQ_MSK];
         end
      end
   end

   // bus clear: held pending until idle, then a fixed pulse
   always_ff @(posedge clk_sys) begin
      if (rst_hw) begin
         clr_pend_r <= 1'b0;
         clr_cnt_r <= 2'h0;
      end else if (clk_en) begin
         if (loc_wr && msg_r[`IBS_CLR_BIT]) begin
            clr_pend_r <= 1'b1; // [R21]
         end else if (clr_pend_r && state_r == ibs_pkg::ST_IDLE) begin
            clr_pend_r <= 1'b0;
            clr_cnt_r <= 2'(`IBS_CLR_CYC); // [R24]
         end else if (clr_cnt_r != 2'h0) begin
            clr_cnt_r <= clr_cnt_r - 2'h1;
         end
      end
   end
   assign bus_clear = (clr_cnt_r != 2'h0); // [R24]

   // initialize count: saturates after the minimum clocks of indication
   always_ff @(posedge clk_sys) begin
      if (rst_hw) begin
         init_cnt_r <= 3'h0;
      end else if (clk_en && init_req && init_cnt_r != 3'(`IBS_INIT_CYC)) begin
         init_cnt_r <= init_cnt_r + 3'h1; // [R22]
      end
   end
   assign initialized = (init_cnt_r == 3'(`IBS_INIT_CYC)) && state_r == ibs_pkg::ST_IDLE &&
      !irq_s && !srq_s && !mem_req && !own_bus_request && !cache_req; // [R23]

   // memory request capture and read data return
   always_ff @(posedge clk_sys) begin
      if (rst_i) begin
         mem_write_r <= 1'b0;
         mem_addr_r <= 24'h00_0000;
         mem_wdata_r <= 16'h0000;
         mem_rdata <= 16'h0000;
         mem_perr_r <= 1'b0;
         fin_r <= 1'b0;
      end else if (clk_en) begin
         if (state_r == ibs_pkg::ST_IDLE && state_nxt == ibs_pkg::ST_MADDR) begin
            mem_write_r <= mem_write; // [R13]
            mem_addr_r <= mem_addr;
            mem_wdata_r <= mem_wdata;
            mem_perr_r <= 1'b0;
         end
         if (state_r == ibs_pkg::ST_MWAIT && cache_done && !mem_write_r) begin
            mem_rdata <= cache_rdata; // [R15]
            mem_perr_r <= cache_rparity_err; // [R16]
         end
         fin_r <= (state_r == ibs_pkg::ST_MFIN);
      end
   end

   // memory handshake lines; data ack trails data and parity by a cycle
   assign cache_req = (state_r == ibs_pkg::ST_MADDR); // [R14] [R15]
   assign cache_write = mem_write_r;
   assign cache_addr = mem_addr_r;
   assign cache_wdata = mem_wdata_r; // [R14]
   assign mem_addr_ack = (state_r == ibs_pkg::ST_MWAIT) || (state_r == ibs_pkg::ST_MFIN);
   assign mem_data_ack = (state_r == ibs_pkg::ST_MFIN) && fin_r; // [R15]
   assign bus_parity_err = (state_r == ibs_pkg::ST_MFIN) && mem_perr_r; // [R16]

   // master command lines; strobe driven only in the handshake, bus request from exec on
   assign msg_fetch = (state_r == ibs_pkg::ST_FETCH); // [R2]
   assign own_bus_request = (state_r == ibs_pkg::ST_EXEC) || (state_r == ibs_pkg::ST_HSHK); // [R8]
   assign cmd_strobe = (state_r == ibs_pkg::ST_HSHK); // [R28]
   assign cmd_addr = msg_addr;
   assign cmd_data = msg_data;
   assign cmd_read = msg_r[`IBS_MSG_RW_BIT];
   assign cmd_global = msg_addr[`IBS_AD_GLOB_BIT];

   // response status word
   always_comb begin
      rsp_status = 16'h0000;
      rsp_status[`IBS_ST_PERR] = perr_r;
      rsp_status[`IBS_ST_TOUT] = tout_r;
      rsp_status[`IBS_ST_DNV] = dnv_r;
      rsp_status[`IBS_ST_IRQ] = irq_s;
      rsp_status[`IBS_ST_SRQ] = srq_s;
      rsp_status[`IBS_ST_LOCAL] = is_local;
   end

   // response word loaded while in response state and on entry to unsolicited state
   always_ff @(posedge clk_sys) begin
      if (rst_i) begin
         rsp_word_r <= 32'h0000_0000;
      end else if (clk_en) begin
         // keeps the last response for software readback
         if (state_r == ibs_pkg::ST_RESP) begin
            rsp_word_r <= {rdata_r, rsp_status}; // [R12]
         end
         if (state_r == ibs_pkg::ST_IDLE && state_nxt == ibs_pkg::ST_UNSOL) begin
            rsp_word_r <= {16'h0000, rsp_status | 16'(1 << `IBS_ST_UNSOL)}; // [R17]
         end
      end
   end
   // error flags and read data land on the entry edge, so the response is built live
   assign rsp_word = (state_r == ibs_pkg::ST_RESP) ? {rdata_r, rsp_status} : rsp_word_r; // [R12]
   assign rsp_valid = (state_r == ibs_pkg::ST_RESP) || (state_r == ibs_pkg::ST_UNSOL); // [R4]

   // apb slave: zero wait, error on unmapped offsets
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(paddr == `IBS_A_CTRL ||
      (!pwrite && (paddr == `IBS_A_STAT || paddr == `IBS_A_RESP)));
   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         `IBS_A_CTRL: prdata = {16'h0000, ctrl0_view};
         `IBS_A_STAT: prdata = {12'h000, 4'(state_r), initialized, bus_clear,
            unsolicited_pending_flag, 1'b0, rsp_status[11:0]};
         `IBS_A_RESP: prdata = rsp_word_r;
         default: prdata = 32'h0000_0000;
      endcase
   end
endmodule

// File: ibs_seq_assertions.sv
// port checker of the bus interface sequencer
`timescale 1ns/1ps
module ibs_seq_assertions (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // message unit side
   input wire logic message_available_n,
   input wire logic msg_fetch,
   input wire logic msg_word_valid,
   input wire logic rsp_valid,
   input wire logic rsp_ack,
   // io bus master side
   input wire logic own_bus_request,
   input wire logic bus_grant,
   input wire logic cmd_strobe,
   input wire logic cmd_global,
   input wire logic [14:0] cmd_addr,
   input wire logic bus_clear,
   // memory path
   input wire logic cache_req,
   input wire logic mem_addr_ack,
   input wire logic mem_data_ack,
   input wire logic bus_parity_err,
   input wire logic initialized
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // broadcast strobe holds on its own, clear pulse is three clocks
   sequence glob_hold; cmd_strobe [*8]; endsequence
   sequence clr_pulse; bus_clear [*3] ##1 !bus_clear; endsequence
   chk_grant_before_cmd: assert property ($rose(cmd_strobe) |-> $past(own_bus_request && bus_grant))
      else $error("strobe without granted bus");
   chk_global_self_end: assert property ($rose(cmd_strobe) && cmd_global |-> glob_hold ##[28:34] !cmd_strobe)
      else $error("broadcast strobe length wrong");
   // consecutive strobe cycles; a long window is counted, not unrolled
   logic [10:0] hs_len_r;
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !cmd_strobe) begin
         hs_len_r <= 11'h000;
      end else if (hs_len_r != 11'h7ff) begin
         hs_len_r <= hs_len_r + 11'h001;
      end
   end
   chk_hshk_bound: assert property (cmd_strobe |-> hs_len_r < 11'h400)
      else $error("handshake not ended in time");
   chk_fetch_held: assert property (msg_fetch && !msg_word_valid |=> msg_fetch)
      else $error("fetch dropped before word");
   chk_rsp_held: assert property (rsp_valid && !rsp_ack && message_available_n |=> rsp_valid)
      else $error("response dropped before ack");
   chk_clear_len: assert property ($rose(bus_clear) |-> clr_pulse)
      else $error("bus clear pulse length wrong");
   chk_no_local_strobe: assert property (cmd_strobe |-> cmd_addr[6:0] != 7'h00)
      else $error("local address sent on bus");
   chk_cache_first: assert property (cache_req |-> !mem_addr_ack && !mem_data_ack)
      else $error("memory ack before cache request");
   chk_perr_early: assert property ($rose(mem_data_ack) |-> $past(mem_addr_ack) && $stable(bus_parity_err))
      else $error("parity error not set before data ack");
   chk_init_quiet: assert property (initialized |-> !(msg_fetch || cmd_strobe || cache_req || own_bus_request))
      else $error("initialized while busy");
endmodule
bind ibs_seq ibs_seq_assertions i_ibs_seq_assertions (.*);

// File: ibs_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ibs_sync (
   // clock and reset
   input wire logic clk_sys,
   input wire logic clk_en,
   input wire logic sys_rst,
   // data
   input wire logic [3:0] d,
   output logic [3:0] q
);
   logic [3:0] meta_r;
   // first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         meta_r <= 4'h0;
         q <= 4'h0;
      end else if (clk_en) begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// File: ibs_tmr_if.sv
// handshake timer control between sequencer and timer
`timescale 1ns/1ps
interface ibs_tmr_if;
   logic run;
   logic global_cmd;
   logic glob_done;
   logic tout;
   modport ctl (output run, output global_cmd, input glob_done, input tout);
   modport tmr (input run, input global_cmd, output glob_done, output tout);
endinterface

// File: tb.sv
// self-checking bench of the bus interface sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
   $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
   logic clk_sys = 0, sys_rst = 1, clk_en = 1, adapter_reset_n = 1, power_on_good = 1;
   logic psel = 0, penable = 0, pwrite = 0, init_req = 0, mute = 0, e;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, msg_word = 0, prdata, rsp_word, r;
   logic message_available_n = 1, interrupt_request_n = 1, channel_service_request_n = 1;
   logic msg_word_valid = 0, msg_parity = 0, rsp_ack = 0, cache_ack = 0, cache_done = 0;
   logic cache_rparity_err = 0, mem_req = 0, mem_write = 0, got = 0, rpe = 0;
   logic [15:0] cache_rdata = 0, mem_wdata = 0, rv = 0, cache_wdata, cmd_data, chan_rdata;
   logic [15:0] mem_rdata;
   logic [23:0] mem_addr = 0, cache_addr;
   logic [14:0] cmd_addr;
   logic pready, pslverr, initialized, bus_clear, msg_fetch, rsp_valid, cache_req;
   logic cache_write, own_bus_request, bus_grant, cmd_strobe, cmd_read, cmd_global;
   logic chan_reply, data_not_valid, mem_addr_ack, mem_data_ack, bus_parity_err;
   int n_errors = 0, total_checks = 0, k;
   ibs_seq i_ibs_seq (.*);
   ibs_chan_model i_ibs_chan_model (.*);
   // clock
   initial forever #12.5 clk_sys = ~clk_sys;
   // cache unit stand-in: one data answer per request
   always @(posedge clk_sys) begin
      cache_ack <= cache_req && !cache_ack;
      cache_done <= mem_addr_ack && !got;
      got <= mem_req && (got || mem_addr_ack);
      cache_rdata <= (mem_addr_ack && !got) ? rv : ~rv;
      cache_rparity_err <= mem_addr_ack && !got && rpe;
   end
   task wrap_up;
      if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      r = prdata; e = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task take;
      do @(posedge clk_sys); while (rsp_valid !== 1'b1);
      r = rsp_word; rsp_ack <= 1;
      @(posedge clk_sys);
      rsp_ack <= 0;
   endtask
   task send(input logic [31:0] w, input logic bad);
      message_available_n <= 0;
      do @(posedge clk_sys); while (msg_fetch !== 1'b1);
      msg_word_valid <= 1; msg_word <= w; msg_parity <= ~^w ^ bad; message_available_n <= 1;
      @(posedge clk_sys);
      msg_word_valid <= 0; msg_word <= ~w;
      take;
   endtask
   task mem(input logic wr, input logic [15:0] v, input logic pe);
      mem_req <= 1; mem_write <= wr; mem_addr <= {8'h12, v}; mem_wdata <= v; rv = v; rpe = pe;
      do @(posedge clk_sys); while (cache_req !== 1'b1);
      `CHK({cache_write, cache_addr}, {wr, 8'h12, v})
      do @(posedge clk_sys); while (mem_data_ack !== 1'b1);
      if (wr) `CHK(cache_wdata, v)
      else `CHK({bus_parity_err, mem_rdata}, {pe, v})
      mem_req <= 0;
      @(posedge clk_sys);
   endtask
   // watchdog
   initial begin
      #(25 * 20000);
      n_errors++;
      wrap_up;
   end
   // main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      sys_rst <= 0;
      repeat (4) @(posedge clk_sys);
      apb(1, 12'h000, 32'h0000_0003);
      apb(0, 12'h000, 32'h0000_0000); `CHK(r[1:0], 2'h3)
      apb(1, 12'h004, 32'hffff_ffff); `CHK(e, 1'b1)
      apb(0, 12'hffc, 32'h0000_0000); `CHK({e, r}, 33'h1_0000_0000)
      // addressed read, broadcast write, silent channel, bad parity
      send({16'h0000, 15'h000a, 1'b1}, 0); `CHK(r, 32'h800a_0000)
      send({16'h1234, 15'h0088, 1'b0}, 0); `CHK(r[15:0], 16'h0000)
      mute <= 1;
      send({16'h0001, 15'h000a, 1'b0}, 0); `CHK(r[15:0], 16'h0006)
      mute <= 0;
      send(32'h0000_0015, 1); `CHK(r[15:0], 16'h0001)
      // unsolicited message held back by a command, then sent
      apb(1, 12'h000, 32'h0000_0001);
      interrupt_request_n <= 0;
      do @(posedge clk_sys); while (rsp_valid !== 1'b1);
      send({16'h0000, 15'h0000, 1'b1}, 0); `CHK({r[31:16], r[6]}, 17'h0_0003)
      apb(0, 12'h000, 32'h0000_0000); `CHK(r[1:0], 2'h1)
      take; `CHK({r[4], r[3]}, 2'h3)
      apb(0, 12'h000, 32'h0000_0000); `CHK(r[1:0], 2'h0)
      repeat (20) @(posedge clk_sys);
      `CHK(rsp_valid, 1'b0)
      interrupt_request_n <= 1;
      // bus clear request, counted over a window
      send({16'h0040, 15'h0000, 1'b0}, 0); `CHK(r[6], 1'b1)
      k = 0;
      repeat (12) begin @(posedge clk_sys); k += int'(bus_clear); end
      `CHK(k, 3)
      mem(1, 16'hbeef, 0);
      mem(0, 16'h5aa5, 0);
      mem(0, 16'hc33c, 1);
      // initialize indication, then a pending request line
      init_req <= 1;
      repeat (3) @(posedge clk_sys);
      `CHK(initialized, 1'b0)
      repeat (5) @(posedge clk_sys);
      `CHK(initialized, 1'b1)
      channel_service_request_n <= 0;
      repeat (4) @(posedge clk_sys);
      `CHK(initialized, 1'b0)
      wrap_up;
   end
endmodule
